// [verilog/osr_scan_regs.v]
// Scan data registers, instruction decode and a small bit FIFO.
// Assumes tck, tdi and the pins are asynchronous and sampled on clk; the TAP
// state levels come from a controller on clk, held for a whole TCK period.
`timescale 1ns/1ps
`default_nettype none
`include "osr_defs.vh"

// Bit FIFO with valid and ready on both sides.
module osr_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at the depth so non power of two depths also work.
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// Boundary, control, bypass and instruction registers with pin muxing.
module osr_scan_regs #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Test port pins.
  input wire tck,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  // TAP controller state levels.
  input wire tap_reset,
  input wire tap_run_idle,
  input wire tap_capture_dr,
  input wire tap_shift_dr,
  input wire tap_update_dr,
  input wire tap_capture_ir,
  input wire tap_shift_ir,
  input wire tap_update_ir,
  // Transceiver pins.
  input wire dir_pin,
  input wire oe_n_pin,
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  output reg [7:0] a_out,
  output reg [7:0] a_oe,
  output reg [7:0] b_out,
  output reg [7:0] b_oe,
  // Normal on-chip logic.
  input wire [7:0] core_out,
  output reg [7:0] core_in,
  output reg test_mode,
  // Stream of bits shifted out at TDO.
  output wire scan_ready,
  output wire mon_valid,
  input wire mon_ready,
  output wire mon_bit
);
  localparam SEL_BYPASS = 3'b001;
  localparam SEL_BSR = 3'b010;
  localparam SEL_BCR = 3'b100;

  // Two-flop synchronisers for everything from outside clk.
  reg [2:0] tck_sync;
  reg [1:0] tdi_sync;
  reg [1:0] dir_sync;
  reg [1:0] oe_sync;
  reg [7:0] a_s1;
  reg [7:0] a_s2;
  reg [7:0] b_s1;
  reg [7:0] b_s2;

  reg [`OSR_BSR_LEN-1:0] bsr_shift;
  reg [`OSR_BSR_LEN-1:0] boundary_register;
  reg [1:0] bcr_shift;
  reg [1:0] boundary_control_register;
  reg bypass_shift;
  reg [`OSR_IR_LEN-1:0] ir_shift;
  reg [`OSR_IR_LEN-1:0] ir;
  reg [`OSR_BSR_LEN-1:0] next_bsr;
  reg [2:0] sel;
  reg dec_test;
  reg dec_highz;
  reg eff_dir;
  reg [7:0] pin_in;
  reg sel_lsb;

  wire tck_rise;
  wire tck_fall;
  wire [6:0] op;
  wire shifting;
  wire [15:0] lfsr16;
  wire [7:0] lfsr8_hi;
  wire [15:0] lfsr8_lo;
  wire [15:0] lfsr8_mix;

  always @(posedge clk) begin
    if (rst) begin
      tck_sync <= 3'h0;
      tdi_sync <= 2'h0;
      dir_sync <= 2'h0;
      oe_sync <= 2'h3;
      a_s1 <= 8'h00;
      a_s2 <= 8'h00;
      b_s1 <= 8'h00;
      b_s2 <= 8'h00;
    end else begin
      tck_sync <= {tck_sync[1:0], tck};
      tdi_sync <= {tdi_sync[0], tdi};
      dir_sync <= {dir_sync[0], dir_pin};
      oe_sync <= {oe_sync[0], oe_n_pin};
      a_s1 <= a_in;
      a_s2 <= a_s1;
      b_s1 <= b_in;
      b_s2 <= b_s1;
    end
  end

  // Edges are found on the second and third stages only.
  assign tck_rise = tck_sync[1] & ~tck_sync[2];
  assign tck_fall = ~tck_sync[1] & tck_sync[2];

  // Galois step of a linear feedback register, used for both widths.
  function [15:0] lfsr_step;
    input [15:0] v;
    input [15:0] taps;
    begin
      lfsr_step = v[0] ? ((v >> 1) ^ taps) : (v >> 1);
    end
  endfunction

  assign op = ir[6:0];

  // Decode the data register and mode; anything unlisted is bypass.
  always @* begin
    sel = SEL_BYPASS;
    dec_test = 1'b0;
    dec_highz = 1'b0;
    case (op)
      `OSR_OP_EXTEST, `OSR_OP_INTEST: begin
        sel = SEL_BSR;
        dec_test = 1'b1;
      end
      `OSR_OP_SAMPLE: begin
        sel = SEL_BSR;
      end
      `OSR_OP_HIGHZ: begin
        dec_highz = 1'b1;
      end
      `OSR_OP_CLAMP, `OSR_OP_RUN_TEST_INSTRUCTION, `OSR_OP_TOGGLE: begin
        dec_test = 1'b1;
      end
      `OSR_OP_READ_N, `OSR_OP_SELFTEST: begin
        sel = SEL_BSR;
      end
      `OSR_OP_READ_T: begin
        sel = SEL_BSR;
        dec_test = 1'b1;
      end
      `OSR_OP_CTL_N: begin
        sel = SEL_BCR;
      end
      `OSR_OP_CTL_T: begin
        sel = SEL_BCR;
        dec_test = 1'b1;
      end
      default: begin
        sel = SEL_BYPASS;
      end
    endcase
  end

  // Direction follows the pin unless test mode is active.
  // Direction picks which port feeds the input cells.
  always @* begin
    eff_dir = test_mode ? boundary_register[`OSR_CELL_DIR] : dir_sync[1];
    pin_in = eff_dir ? a_s2 : b_s2;
  end

  assign lfsr16 = lfsr_step(bsr_shift[15:0], `OSR_LFSR16_TAPS);
  assign lfsr8_hi = bsr_shift[15:8] ^ pin_in;
  assign lfsr8_lo = lfsr_step({8'h00, bsr_shift[7:0]},
    {8'h00, `OSR_LFSR8_TAPS});
  // The upper half compresses the inputs before its own step.
  assign lfsr8_mix = lfsr_step({8'h00, lfsr8_hi},
    {8'h00, `OSR_LFSR8_TAPS});

  // Next boundary shift contents for capture, shift and run-test edges.
  always @* begin
    next_bsr = bsr_shift;
    if (tap_capture_dr && sel == SEL_BSR) begin
      if (op == `OSR_OP_SELFTEST) begin
        next_bsr = ~boundary_register;
      end else if (op != `OSR_OP_READ_N && op != `OSR_OP_READ_T) begin
        next_bsr = {dir_sync[1], oe_sync[1], pin_in, core_out};
      end
    end else if (tap_shift_dr && sel == SEL_BSR) begin
      next_bsr = {tdi_sync[1], bsr_shift[`OSR_BSR_LEN-1:1]};
    end else if (tap_run_idle && op == `OSR_OP_TOGGLE) begin
      next_bsr[7:0] = ~bsr_shift[7:0];
    end else if (tap_run_idle && op == `OSR_OP_RUN_TEST_INSTRUCTION) begin
      // Cells 17 and 16 are kept.
      case (boundary_control_register)
        `OSR_BCR_TOGGLE: begin
          next_bsr[15:0] = {pin_in, ~bsr_shift[7:0]};
        end
        `OSR_BCR_PATTERN: begin
          next_bsr[15:0] = lfsr16;
        end
        `OSR_BCR_SIGNATURE: begin
          next_bsr[15:0] = lfsr16 ^ {pin_in, 8'h00};
        end
        `OSR_BCR_BOTH: begin
          next_bsr[15:0] = {lfsr8_mix[7:0], lfsr8_lo[7:0]};
        end
        default: begin
          next_bsr = bsr_shift;
        end
      endcase
    end
  end

  // Shift stages move on the TCK rising edge.
  // Test-logic reset never touches the boundary cells.
  always @(posedge clk) begin
    if (rst) begin
      bsr_shift <= {`OSR_BSR_LEN{1'b0}};
      bcr_shift <= `OSR_BCR_RESET;
      bypass_shift <= 1'b0;
      ir_shift <= `OSR_IR_RESET;
    end else if (tck_rise) begin
      bsr_shift <= next_bsr;
      if (tap_reset) begin
        bcr_shift <= `OSR_BCR_RESET;
      end else if (tap_shift_dr && sel == SEL_BCR) begin
        bcr_shift <= {tdi_sync[1], bcr_shift[1]};
      end
      if (tap_capture_dr && sel == SEL_BYPASS) begin
        bypass_shift <= 1'b0;
      end else if (tap_shift_dr && sel == SEL_BYPASS) begin
        bypass_shift <= tdi_sync[1];
      end
      if (tap_capture_ir) begin
        ir_shift <= `OSR_IR_CAPTURE;
      end else if (tap_shift_ir) begin
        ir_shift <= {tdi_sync[1], ir_shift[`OSR_IR_LEN-1:1]};
      end
    end
  end

  // Latches move on the TCK falling edge, with TDO.
  always @(posedge clk) begin
    if (rst) begin
      boundary_register <= {`OSR_BSR_LEN{1'b0}};
      boundary_control_register <= `OSR_BCR_RESET;
      ir <= `OSR_IR_RESET;
    end else if (tck_fall) begin
      if (tap_reset) begin
        ir <= `OSR_IR_RESET;
        boundary_control_register <= `OSR_BCR_RESET;
      end else if (tap_update_ir) begin
        ir <= ir_shift;
      end else if (tap_update_dr && sel == SEL_BCR) begin
        boundary_control_register <= bcr_shift;
      end
      if (tap_update_dr && sel == SEL_BSR) begin
        boundary_register <= bsr_shift;
      end else if (tap_run_idle && op == `OSR_OP_TOGGLE) begin
        boundary_register[7:0] <= bsr_shift[7:0];
      end else if (tap_run_idle && op == `OSR_OP_RUN_TEST_INSTRUCTION) begin
        boundary_register[15:0] <= bsr_shift[15:0];
      end
    end
  end

  // The scan path output is chosen by the active shift state.
  always @* begin
    if (tap_shift_ir) begin
      sel_lsb = ir_shift[0];
    end else begin
      case (sel)
        SEL_BSR: sel_lsb = bsr_shift[0];
        SEL_BCR: sel_lsb = bcr_shift[0];
        default: sel_lsb = bypass_shift;
      endcase
    end
  end

  assign shifting = tap_shift_dr | tap_shift_ir;

  // TDO enables and changes on the falling edge, as the standard expects.
  always @(posedge clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= shifting ? sel_lsb : 1'b0;
      tdo_oe <= shifting;
    end
  end

  // Each bit leaving the chain is also queued for a local observer.
  // A full queue drops scan_ready, and the controller must hold TCK.
  osr_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_mon_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(tck_rise & shifting),
    .in_ready(scan_ready),
    .in_data(sel_lsb),
    .out_valid(mon_valid),
    .out_ready(mon_ready),
    .out_data(mon_bit)
  );

  // Pin drive: test modes use the latches, highz floats both ports.
  // Output cells drive the output side.
  always @(posedge clk) begin
    if (rst) begin
      a_out <= 8'h00;
      b_out <= 8'h00;
      a_oe <= 8'h00;
      b_oe <= 8'h00;
      core_in <= 8'h00;
      test_mode <= 1'b0;
    end else begin
      test_mode <= dec_test;
      core_in <= dec_test ? boundary_register[15:8] : pin_in;
      if (dec_highz) begin
        a_oe <= 8'h00;
        b_oe <= 8'h00;
      end else if (dec_test) begin
        a_out <= boundary_register[7:0];
        b_out <= boundary_register[7:0];
        a_oe <= {8{~boundary_register[`OSR_CELL_OE_N] & ~eff_dir}};
        b_oe <= {8{~boundary_register[`OSR_CELL_OE_N] & eff_dir}};
      end else begin
        a_out <= core_out;
        b_out <= core_out;
        a_oe <= {8{~oe_sync[1] & ~eff_dir}};
        b_oe <= {8{~oe_sync[1] & eff_dir}};
      end
    end
  end
endmodule
`default_nettype wire

// [verilog/osr_defs.vh]
// Constants for the octal transceiver scan registers block.
// Assumes a TAP controller elsewhere supplies its state as levels on clk.
`ifndef OSR_DEFS_VH
`define OSR_DEFS_VH
`define OSR_BSR_LEN 18
`define OSR_CELL_DIR 17
`define OSR_CELL_OE_N 16
`define OSR_IR_LEN 8
`define OSR_IR_CAPTURE 8'h81
`define OSR_IR_RESET 8'hFF
`define OSR_BCR_RESET 2'h2
`define OSR_OP_EXTEST 7'h00
`define OSR_OP_SAMPLE 7'h02
`define OSR_OP_INTEST 7'h03
`define OSR_OP_HIGHZ 7'h06
`define OSR_OP_CLAMP 7'h07
`define OSR_OP_RUN_TEST_INSTRUCTION 7'h09
`define OSR_OP_READ_N 7'h0A
`define OSR_OP_READ_T 7'h0B
`define OSR_OP_SELFTEST 7'h0C
`define OSR_OP_TOGGLE 7'h0D
`define OSR_OP_CTL_N 7'h0E
`define OSR_OP_CTL_T 7'h0F
`define OSR_BCR_TOGGLE 2'h0
`define OSR_BCR_PATTERN 2'h1
`define OSR_BCR_SIGNATURE 2'h2
`define OSR_BCR_BOTH 2'h3
`define OSR_LFSR16_TAPS 16'hB400
`define OSR_LFSR8_TAPS 8'hB8
`endif

// [tb/osr_scan_regs_chk.sv]
// Checker bound to the scan register block top ports.
// Assumes pins and TAP levels are held for several clk cycles at a time.
`timescale 1ns/1ps
`default_nettype none
module osr_scan_regs_chk #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock, reset and test port.
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tap_shift_dr,
  input wire logic tap_shift_ir,
  // Transceiver pins and mode.
  input wire logic dir_pin,
  input wire logic oe_n_pin,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] a_out,
  input wire logic [7:0] b_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] core_out,
  input wire logic [7:0] core_in,
  input wire logic test_mode,
  // Monitor stream.
  input wire logic scan_ready,
  input wire logic mon_valid,
  input wire logic mon_ready,
  input wire logic mon_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Five steady cycles cover the two pin flops and the output register.
  // The pin data goes to the core; the core data goes to the output side.
  sequence s_norm_ab;
    (!test_mode && !oe_n_pin && dir_pin && $stable(a_in) &&
      $stable(core_out)) [*5];
  endsequence
  sequence s_norm_ba;
    (!test_mode && !oe_n_pin && !dir_pin && $stable(b_in) &&
      $stable(core_out)) [*5];
  endsequence
  property p_norm_ab;
    s_norm_ab |-> core_in == a_in && b_out == core_out &&
      b_oe == 8'hFF && a_oe == 8'h00;
  endproperty
  property p_norm_ba;
    s_norm_ba |-> core_in == b_in && a_out == core_out &&
      a_oe == 8'hFF && b_oe == 8'h00;
  endproperty
  property p_float;
    (!test_mode && oe_n_pin) [*5] |-> a_oe == 8'h00 && b_oe == 8'h00;
  endproperty
  property p_one_side;
    !(|a_oe && |b_oe);
  endproperty
  property p_whole;
    a_oe inside {8'h00, 8'hFF} && b_oe inside {8'h00, 8'hFF};
  endproperty
  // The scan output may only move after a falling test clock edge.
  property p_tdo_fall;
    $changed(tdo) |-> !$past(tck, 2);
  endproperty
  property p_tdo_on;
    $rose(tdo_oe) |-> $past(tap_shift_dr, 2) || $past(tap_shift_ir, 2);
  endproperty
  property p_full;
    !scan_ready |-> mon_valid;
  endproperty
  property p_mon_hold;
    mon_valid && !mon_ready |=> mon_valid && $stable(mon_bit);
  endproperty
  a_norm_ab: assert property (p_norm_ab)
    else $error("Normal A to B path wrong.");
  a_norm_ba: assert property (p_norm_ba)
    else $error("Normal B to A path wrong.");
  a_float: assert property (p_float)
    else $error("Disabled port still driven.");
  a_one_side: assert property (p_one_side)
    else $error("Both ports driven.");
  a_whole: assert property (p_whole)
    else $error("Port enable split across bits.");
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("Scan output moved off a falling edge.");
  a_tdo_on: assert property (p_tdo_on)
    else $error("Scan output enabled outside a shift.");
  a_full: assert property (p_full)
    else $error("Queue refuses while empty.");
  a_mon_hold: assert property (p_mon_hold)
    else $error("Stream bit dropped while stalled.");
endmodule
bind osr_scan_regs osr_scan_regs_chk #(
  .FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)
) osr_scan_regs_chk_i (
  .clk(clk), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .tap_shift_dr(tap_shift_dr), .tap_shift_ir(tap_shift_ir),
  .dir_pin(dir_pin), .oe_n_pin(oe_n_pin), .a_in(a_in), .b_in(b_in),
  .a_out(a_out), .b_out(b_out), .a_oe(a_oe), .b_oe(b_oe),
  .core_out(core_out), .core_in(core_in),
  .test_mode(test_mode), .scan_ready(scan_ready), .mon_valid(mon_valid),
  .mon_ready(mon_ready), .mon_bit(mon_bit)
);
`default_nettype wire

// [tb/osr_jtag_host.sv]
// Test controller model that paces TCK and the TAP state levels.
// Assumes the block samples tck on clk; outputs change on clk rises.
`timescale 1ns/1ps
`default_nettype none
module osr_jtag_host (
  // Clock.
  input wire logic clk,
  // Scan port.
  output logic tck,
  output logic tdi,
  output logic [7:0] tap_lv,
  input wire logic tdo,
  input wire logic scan_ready
);
  logic [31:0] q;
  int hang;
  // TCK starts low and rests high between frames; TDI idles high, as if pulled up.
  initial begin
    tck = 1'b0;
    tdi = 1'b1;
    tap_lv = 8'h01;
    q = 32'h0;
    hang = 0;
  end
  // One TCK period in state s; levels and TDI move with the falling edge.
  task automatic step(input int s, input logic b);
    int k;
    k = 0;
    tap_lv <= 8'(1 << s);
    tdi <= b;
    tck <= 1'b0;
    repeat (4) @(posedge clk);
    // Hold the clock low while the monitor queue is full.
    while (!scan_ready && k < 400) begin
      k++;
      @(posedge clk);
    end
    if (k == 400) hang++;
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    if (s == 3 || s == 6) q = {tdo, q[31:1]};
  endtask
  // Capture state c, n shifts of d, exit, update, idle.
  task automatic scan(input int c, input int n, input logic [31:0] d,
                      output logic [31:0] r);
    step(c, 1'b1);
    for (int i = 0; i < n; i++) step(c + 1, d[i]);
    step(8, 1'b1);
    step(c + 2, 1'b1);
    step(1, 1'b1);
    r = q >> (32 - n);
  endtask
endmodule
`default_nettype wire

// [tb/osr_scan_regs_bench.sv]
// Self-checking bench for the scan register block and its stream.
// Assumes the host model's step task paces every TCK period.
`timescale 1ns/1ps
`default_nettype none
module osr_scan_regs_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dir_pin, oe_n_pin, mon_ready, hi;
  logic [7:0] a_in, b_in, core_out, op;
  logic [31:0] r;
  logic [17:0] mq = 18'h0;
  wire tck, tdi, tdo, tdo_oe, test_mode, scan_ready, mon_valid, mon_bit;
  wire [7:0] tap_lv, a_out, a_oe, b_out, b_oe, core_in;
  int n_fail = 0;
  int num_checks = 0;
  int idx, len, k;
  always #12.5 clk = ~clk;
  osr_scan_regs #(.FIFO_DEPTH(8), .FIFO_AW(3)) osr_scan_regs_i (
    .clk(clk), .rst(rst), .tck(tck), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .tap_reset(tap_lv[0]), .tap_run_idle(tap_lv[1]),
    .tap_capture_dr(tap_lv[2]), .tap_shift_dr(tap_lv[3]),
    .tap_update_dr(tap_lv[4]), .tap_capture_ir(tap_lv[5]),
    .tap_shift_ir(tap_lv[6]), .tap_update_ir(tap_lv[7]),
    .dir_pin(dir_pin), .oe_n_pin(oe_n_pin), .a_in(a_in), .b_in(b_in),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .core_out(core_out), .core_in(core_in), .test_mode(test_mode),
    .scan_ready(scan_ready), .mon_valid(mon_valid), .mon_ready(mon_ready),
    .mon_bit(mon_bit));
  osr_jtag_host osr_jtag_host_i (.clk(clk), .tck(tck), .tdi(tdi),
    .tap_lv(tap_lv), .tdo(tdo), .scan_ready(scan_ready));
  // Collect the stream, newest bit on top.
  always @(posedge clk) begin
    if (mon_valid && mon_ready) mq <= {mon_bit, mq[17:1]};
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic ir_scan(input logic [7:0] o);
    osr_jtag_host_i.scan(5, 8, {24'h0, o}, r);
  endtask
  task automatic dr_scan(input int n, input logic [31:0] d);
    osr_jtag_host_i.scan(2, n, d, r);
  endtask
  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report;
  end
  initial begin
    dir_pin = 1'b1;
    oe_n_pin = 1'b0;
    a_in = 8'h5A;
    b_in = 8'h3C;
    core_out = 8'hC3;
    mon_ready = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    osr_jtag_host_i.step(0, 1'b1);
    osr_jtag_host_i.step(1, 1'b1);
    dr_scan(2, 32'h3);
    check(r, 32'h2);
    ir_scan(8'h82);
    check(r, 32'h81);
    $display("Reset and capture test done");
    // Capture with the stream stalled until the queue refuses.
    mon_ready <= 1'b0;
    fork
      dr_scan(18, 32'h2A596);
      begin
        k = 0;
        while (scan_ready !== 1'b0 && k < 400) begin
          k++;
          @(posedge clk);
        end
        check(scan_ready, 32'h0);
        repeat (30) @(posedge clk);
        mon_ready <= 1'b1;
      end
    join
    check(r, 32'h25AC3);
    check(mq, 18'h25AC3);
    check(mon_valid, 32'h0);
    dir_pin <= 1'b0;
    repeat (8) @(posedge clk);
    dr_scan(18, 32'h01169);
    check(r, 32'h03CC3);
    ir_scan(8'h0A);
    dr_scan(18, 32'h2A596);
    check(r, 32'h01169);
    $display("Sample and read test done");
    ir_scan(8'h00);
    check({test_mode, b_oe, a_oe, b_out}, {1'b1, 24'hFF0096});
    check(core_in, 32'hA5);
    dr_scan(18, 32'h01169);
    check({a_oe, b_oe, a_out, core_in}, 32'hFF006911);
    oe_n_pin <= 1'b1;
    ir_scan(8'h07);
    check({test_mode, a_oe, a_out}, {1'b1, 16'hFF69});
    ir_scan(8'h06);
    check({a_oe, b_oe}, 32'h0);
    $display("Pin drive test done");
    ir_scan(8'h0E);
    dr_scan(2, 32'h1);
    check(r, 32'h2);
    dr_scan(2, 32'h1);
    check(r, 32'h1);
    osr_jtag_host_i.step(0, 1'b1);
    osr_jtag_host_i.step(1, 1'b1);
    ir_scan(8'h0E);
    dr_scan(2, 32'h0);
    check(r, 32'h2);
    ir_scan(8'h0A);
    dr_scan(18, 32'h0);
    check(r, 32'h01169);
    $display("Control register test done");
    // Codes 00 to 0F, 10, 7F and 89: path length from the bit fed in, and the mode.
    for (int i = 0; i < 19; i++) begin
      op = i < 16 ? 8'(i) : (i == 16 ? 8'h10 : (i == 17 ? 8'h7F : 8'h89));
      idx = op[3:0];
      hi = |op[6:4];
      len = 1;
      if (!hi && 16'h1C0D >> idx & 1) len = 18;
      if (!hi && 16'hC000 >> idx & 1) len = 2;
      ir_scan(op);
      dr_scan(len + 1, 32'h1);
      check(r[len], 32'h1);
      if (len == 1) check(r[0], 32'h0);
      if (idx != 6 || hi) check(test_mode, !hi && (16'hAA89 >> idx & 1));
    end
    $display("Opcode table test done");
    // Self test reads back inverted latches; toggle flips the outputs.
    ir_scan(8'h02);
    dr_scan(18, 32'h0A55A);
    ir_scan(8'h0C);
    dr_scan(18, 32'h0A55A);
    check(r, 32'h35AA5);
    ir_scan(8'h0D);
    op = a_out;
    osr_jtag_host_i.step(1, 1'b1);
    check(a_out, 8'(~op));
    check(core_in, 32'hA5);
    // Every control code must move the cells but keep cells 17 and 16.
    for (int c = 0; c < 4; c++) begin
      ir_scan(8'h0E);
      dr_scan(2, c);
      ir_scan(8'h02);
      dr_scan(18, 32'h3A55A);
      ir_scan(8'h09);
      repeat (3) osr_jtag_host_i.step(1, 1'b1);
      ir_scan(8'h0A);
      dr_scan(18, 32'h0);
      check(r[17:16], 32'h3);
      check(r[15:0] != 16'hA55A, 32'h1);
      if (c == 0) check(r[15:8], a_in);
    end
    $display("Run test and self test done");
    n_fail += osr_jtag_host_i.hang;
    final_report;
  end
endmodule
`default_nettype wire
